//--- sbr_uart.sv
// Functional notes
// - all-low frame sets framing error flag
// - receiver keeps running through a break
// - software reads receive pin level directly
// - transmit disabled: pin follows port registers
// - direction and data high hold mark
// - disabling transmit resets transmitter immediately
// - sync mode: errors block transmit start
// - receive disable keeps error flags
// - receiver runs on sixteen-times basic clock
// - start falling edge detected on basic clock
// - bits latched at eighth basic pulse
// - async frames of 9 to 12 bits, sync mode sends 8 bits
// - error flags set block further reception
// - receive error interrupt when enabled
`timescale 1ns/1ps
`default_nettype none

module sbr_uart
    import sbr_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // clock, reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [SBR_AW-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [SBR_AW-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // serial pins
    input wire logic rxd_pin,
    output logic txd_out,
    output logic txd_oe,
    output logic sck_out,
    // interrupts
    output logic irq,
    output logic rx_error_irq
);

    if (DIV_W < 1 || DIV_W > 16) begin : g_chk
        $error("sbr_uart: DIV_W must be 1 to 16");
    end

    typedef struct packed {
        logic [7:0] ctrl;
        logic port_direction_reg;
        logic port_data_reg;
        logic [DIV_W-1:0] baud;
        logic [7:0] txdata;
        logic [7:0] rxdata;
        logic [4:0] flags;
        logic [4:0] irq_en;
        logic [DIV_W-1:0] div_cnt;
        logic tick;
        logic tx_busy;
        logic [3:0] tx_cnt;
        logic [3:0] tx_left;
        logic [11:0] tx_shift;
        logic txd_out;
        logic txd_oe;
        logic sck_out;
        logic rx_meta;
        logic rx_sync;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [SBR_AW-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic irq;
        logic rx_error_irq;
    } sbr_state_t;

    sbr_state_t s;
    sbr_state_t next_s;
    sbr_frame_cfg_t cfg;
    sbr_rx_frame_t rx_frame;
    logic rx_done;
    logic err;
    logic sync_mode;
    logic tx_start;
    logic [11:0] tx_frame;
    logic [3:0] nd;
    logic [31:0] merged;
    logic [7:0] status;
    sbr_sel_t wsel;
    sbr_sel_t rsel;

    function automatic sbr_sel_t sbr_decode(input logic [SBR_AW-1:0] a);
        if (a == SBR_CTRL_OFS) begin
            return SBR_SEL_CTRL;
        end else if (a == SBR_PORT_OFS) begin
            return SBR_SEL_PORT;
        end else if (a == SBR_BAUD_OFS) begin
            return SBR_SEL_BAUD;
        end else if (a == SBR_TXD_OFS) begin
            return SBR_SEL_TXD;
        end else if (a == SBR_RXD_OFS) begin
            return SBR_SEL_RXD;
        end else if (a == SBR_STAT_OFS) begin
            return SBR_SEL_STAT;
        end else if (a == SBR_CLR_OFS) begin
            return SBR_SEL_CLR;
        end else if (a == SBR_IEN_OFS) begin
            return SBR_SEL_IEN;
        end else begin
            return SBR_SEL_NONE;
        end
    endfunction

    assign cfg = '{data7: s.ctrl[SBR_C_DATA7], parity_en: s.ctrl[SBR_C_PAR_EN],
                   parity_odd: s.ctrl[SBR_C_PAR_ODD], stop2: s.ctrl[SBR_C_STOP2]};

    sbr_rx_sampler u_rx (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .enable(s.ctrl[SBR_C_RE]),
        .tick(s.tick),
        .cfg(cfg),
        .rxd(s.rx_sync),
        .done(rx_done),
        .frame(rx_frame)
    );

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign txd_out = s.txd_out;
    assign txd_oe = s.txd_oe;
    assign sck_out = s.sck_out;
    assign irq = s.irq;
    assign rx_error_irq = s.rx_error_irq;

    always_comb begin
        next_s = s;
        sync_mode = s.ctrl[SBR_C_SYNC];
        err = s.flags[SBR_S_OER] | s.flags[SBR_S_FER] | s.flags[SBR_S_PER];
        status = {1'b0, s.tx_busy, s.rx_sync, s.flags};
        wsel = sbr_decode(s.awaddr);
        rsel = sbr_decode(araddr);
        merged = 32'h0000_0000;

        // pin synchroniser: only the second stage is looked at
        next_s.rx_meta = rxd_pin;
        next_s.rx_sync = s.rx_meta;

        // basic clock: one tick per (baud + 1) cycles, sixteen per bit
        next_s.tick = 1'b0;
        if (s.div_cnt >= s.baud) begin
            next_s.div_cnt = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = s.div_cnt + 1'b1;
        end

        // write channel: address and data in either order
        if (awvalid && s.awready) begin
            next_s.aw_got = 1'b1;
            next_s.awready = 1'b0;
            next_s.awaddr = awaddr;
        end
        if (wvalid && s.wready) begin
            next_s.w_got = 1'b1;
            next_s.wready = 1'b0;
            next_s.wdata = wdata;
            next_s.wstrb = wstrb;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = SBR_OKAY;
            if (wsel == SBR_SEL_CTRL) begin
                merged = sbr_merge({24'h00_0000, s.ctrl}, s.wdata, s.wstrb);
                next_s.ctrl = merged[7:0];
            end else if (wsel == SBR_SEL_PORT) begin
                if (s.wstrb[0]) begin
                    next_s.port_direction_reg = s.wdata[SBR_P_DIR];
                    next_s.port_data_reg = s.wdata[SBR_P_DATA];
                end
            end else if (wsel == SBR_SEL_BAUD) begin
                merged = sbr_merge(32'(s.baud), s.wdata, s.wstrb);
                next_s.baud = merged[DIV_W-1:0];
            end else if (wsel == SBR_SEL_TXD) begin
                if (s.wstrb[0]) begin
                    next_s.txdata = s.wdata[7:0];
                    next_s.flags[SBR_S_TX_DATA_EMPTY_FLAG] = 1'b0;
                end
            end else if (wsel == SBR_SEL_CLR) begin
                // data-empty is not software-clearable here
                if (s.wstrb[0]) begin
                    next_s.flags[4:1] = s.flags[4:1] & ~s.wdata[4:1];
                end
            end else if (wsel == SBR_SEL_IEN) begin
                if (s.wstrb[0]) begin
                    next_s.irq_en = s.wdata[4:0];
                end
            end else if (wsel == SBR_SEL_NONE) begin
                next_s.bresp = SBR_SLVERR;
            end
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end

        // read channel
        if (arvalid && s.arready) begin
            next_s.arready = 1'b0;
            next_s.rvalid = 1'b1;
            next_s.rresp = SBR_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (rsel == SBR_SEL_CTRL) begin
                next_s.rdata[7:0] = s.ctrl;
            end else if (rsel == SBR_SEL_PORT) begin
                next_s.rdata[SBR_P_DIR] = s.port_direction_reg;
                next_s.rdata[SBR_P_DATA] = s.port_data_reg;
            end else if (rsel == SBR_SEL_BAUD) begin
                next_s.rdata = 32'(s.baud);
            end else if (rsel == SBR_SEL_TXD) begin
                next_s.rdata[7:0] = s.txdata;
            end else if (rsel == SBR_SEL_RXD) begin
                next_s.rdata[7:0] = s.rxdata;
            end else if (rsel == SBR_SEL_STAT) begin
                next_s.rdata[7:0] = status;
            end else if (rsel == SBR_SEL_IEN) begin
                next_s.rdata[4:0] = s.irq_en;
            end else if (rsel == SBR_SEL_NONE) begin
                next_s.rresp = SBR_SLVERR;
            end
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end

        // receive completion; applied after the clear so a set wins
        if (rx_done && s.ctrl[SBR_C_RE] && !err) begin
            if (s.flags[SBR_S_RX_DATA_FULL_FLAG]) begin
                next_s.flags[SBR_S_OER] = 1'b1;
            end else begin
                next_s.rxdata = rx_frame.data;
                next_s.flags[SBR_S_RX_DATA_FULL_FLAG] = 1'b1;
                if (!rx_frame.stop_ok) begin
                    next_s.flags[SBR_S_FER] = 1'b1;
                end
                if (cfg.parity_en && !rx_frame.parity_ok) begin
                    next_s.flags[SBR_S_PER] = 1'b1;
                end
            end
        end

        // transmitter: frame image, bit 0 shifted out first
        nd = cfg.data7 ? 4'h7 : 4'h8;
        tx_frame = 12'hFFF;
        if (sync_mode) begin
            tx_frame[7:0] = s.txdata;
        end else begin
            tx_frame[0] = 1'b0;
            for (int i = 0; i < 8; i++) begin
                if (4'(i) < nd) begin
                    tx_frame[i + 1] = s.txdata[i];
                end
            end
            if (cfg.parity_en) begin
                tx_frame[nd + 4'h1] = (^(s.txdata & {~cfg.data7, 7'h7F})) ^ cfg.parity_odd;
            end
        end
        tx_start = s.ctrl[SBR_C_TE] && !s.tx_busy && !s.flags[SBR_S_TX_DATA_EMPTY_FLAG] &&
                   !(sync_mode && err);

        if (!s.ctrl[SBR_C_TE]) begin
            // drop any frame in flight at once
            next_s.tx_busy = 1'b0;
            next_s.tx_cnt = 4'h0;
            next_s.tx_left = 4'h0;
            next_s.tx_shift = 12'hFFF;
        end else if (tx_start) begin
            next_s.tx_busy = 1'b1;
            next_s.tx_cnt = 4'h0;
            next_s.tx_shift = tx_frame;
            next_s.tx_left = sync_mode ? SBR_SYNC_BITS : sbr_frame_len(cfg);
            next_s.flags[SBR_S_TX_DATA_EMPTY_FLAG] = 1'b1;
        end else if (s.tx_busy && s.tick) begin
            next_s.tx_cnt = s.tx_cnt + 4'h1;
            if (s.tx_cnt == SBR_BIT_LAST) begin
                next_s.tx_shift = {1'b1, s.tx_shift[11:1]};
                next_s.tx_left = s.tx_left - 4'h1;
                if (s.tx_left == 4'h1) begin
                    next_s.tx_busy = 1'b0;
                end
            end
        end

        // pin drive is registered so the pin never glitches
        if (next_s.ctrl[SBR_C_TE]) begin
            next_s.txd_oe = 1'b1;
            next_s.txd_out = next_s.tx_busy ? next_s.tx_shift[0] : 1'b1;
        end else begin
            next_s.txd_oe = next_s.port_direction_reg;
            next_s.txd_out = next_s.port_data_reg;
        end
        // clock out: low in first half of each bit, idle high
        next_s.sck_out = !(next_s.ctrl[SBR_C_TE] && next_s.ctrl[SBR_C_SYNC] &&
                           next_s.tx_busy && !next_s.tx_cnt[3]);

        next_s.irq = |(next_s.flags & next_s.irq_en);
        next_s.rx_error_irq = next_s.ctrl[SBR_C_RIE] &&
            (next_s.flags[SBR_S_OER] | next_s.flags[SBR_S_FER] |
             next_s.flags[SBR_S_PER]);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.ctrl <= SBR_CTRL_RST;
            s.baud <= SBR_BAUD_RST[DIV_W-1:0];
            s.flags <= SBR_FLAGS_RST;
            s.tx_shift <= 12'hFFF;
            s.rx_meta <= 1'b1;
            s.rx_sync <= 1'b1;
            s.sck_out <= 1'b1;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

//--- sbr_pkg.sv
package sbr_pkg;

    // register byte offsets on the AXI4-Lite slave
    localparam int SBR_AW = 5;
    localparam logic [SBR_AW-1:0] SBR_CTRL_OFS = 5'h00;
    localparam logic [SBR_AW-1:0] SBR_PORT_OFS = 5'h04;
    localparam logic [SBR_AW-1:0] SBR_BAUD_OFS = 5'h08;
    localparam logic [SBR_AW-1:0] SBR_TXD_OFS = 5'h0C;
    localparam logic [SBR_AW-1:0] SBR_RXD_OFS = 5'h10;
    localparam logic [SBR_AW-1:0] SBR_STAT_OFS = 5'h14;
    localparam logic [SBR_AW-1:0] SBR_CLR_OFS = 5'h18;
    localparam logic [SBR_AW-1:0] SBR_IEN_OFS = 5'h1C;

    // control register fields
    localparam int SBR_C_TE = 0;
    localparam int SBR_C_RE = 1;
    localparam int SBR_C_SYNC = 2;
    localparam int SBR_C_PAR_EN = 3;
    localparam int SBR_C_PAR_ODD = 4;
    localparam int SBR_C_STOP2 = 5;
    localparam int SBR_C_DATA7 = 6;
    localparam int SBR_C_RIE = 7;
    // port register fields
    localparam int SBR_P_DIR = 0;
    localparam int SBR_P_DATA = 1;
    // status / clear / enable fields
    localparam int SBR_S_TX_DATA_EMPTY_FLAG = 0;
    localparam int SBR_S_RX_DATA_FULL_FLAG = 1;
    localparam int SBR_S_OER = 2;
    localparam int SBR_S_FER = 3;
    localparam int SBR_S_PER = 4;
    localparam int SBR_S_RXPIN = 5;
    localparam int SBR_S_TXBUSY = 6;

    // reset values
    localparam logic [7:0] SBR_CTRL_RST = 8'h00;
    localparam logic [4:0] SBR_FLAGS_RST = 5'h01;
    localparam logic [15:0] SBR_BAUD_RST = 16'h0000;

    // sampling timing in basic-clock pulses
    localparam int SBR_OVERSAMPLE = 16;
    localparam logic [3:0] SBR_SAMPLE_POINT = 4'h7;
    localparam logic [3:0] SBR_BIT_LAST = 4'hF;
    localparam logic [3:0] SBR_SYNC_BITS = 4'h8;

    localparam logic [1:0] SBR_OKAY = 2'b00;
    localparam logic [1:0] SBR_SLVERR = 2'b10;

    typedef enum logic [3:0] {
        SBR_SEL_CTRL, SBR_SEL_PORT, SBR_SEL_BAUD, SBR_SEL_TXD,
        SBR_SEL_RXD, SBR_SEL_STAT, SBR_SEL_CLR, SBR_SEL_IEN, SBR_SEL_NONE
    } sbr_sel_t;

    typedef struct packed {
        logic data7;
        logic parity_en;
        logic parity_odd;
        logic stop2;
    } sbr_frame_cfg_t;

    typedef struct packed {
        logic [7:0] data;
        logic parity_ok;
        logic stop_ok;
    } sbr_rx_frame_t;

    // start + data + optional parity + stop bits, 9 to 12
    function automatic logic [3:0] sbr_frame_len(input sbr_frame_cfg_t c);
        logic [3:0] n;
        n = c.data7 ? 4'h9 : 4'hA;
        n = n + {3'b000, c.parity_en} + {3'b000, c.stop2};
        return n;
    endfunction

    function automatic logic [31:0] sbr_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return (old & ~m) | (data & m);
    endfunction

endpackage

//--- sbr_rx_sampler.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_rx_sampler
    import sbr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // control
    input wire logic enable,
    input wire logic tick,
    input wire sbr_frame_cfg_t cfg,
    // synchronised line level
    input wire logic rxd,
    // frame result
    output logic done,
    output sbr_rx_frame_t frame
);

    typedef enum logic {RX_IDLE, RX_RUN} sbr_rx_st_t;

    typedef struct packed {
        sbr_rx_st_t st;
        logic [3:0] cnt;
        logic [3:0] bit_idx;
        logic [11:0] shift;
        logic last_rx;
        logic done;
        sbr_rx_frame_t frame;
    } sbr_rx_state_t;

    sbr_rx_state_t s;
    sbr_rx_state_t next_s;
    logic [11:0] bits;
    logic [3:0] len;
    logic [3:0] pidx;
    logic [3:0] sidx;

    assign done = s.done;
    assign frame = s.frame;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        bits = s.shift;
        bits[s.bit_idx] = rxd;
        len = sbr_frame_len(cfg);
        pidx = cfg.data7 ? 4'h8 : 4'h9;
        sidx = pidx + {3'b000, cfg.parity_en};
        if (!enable) begin
            next_s.st = RX_IDLE;
            next_s.cnt = 4'h0;
            next_s.bit_idx = 4'h0;
            next_s.last_rx = 1'b1;
        end else if (tick) begin
            next_s.last_rx = rxd;
            case (s.st)
                RX_IDLE: begin
                    if (s.last_rx && !rxd) begin
                        next_s.st = RX_RUN;
                        next_s.cnt = 4'h0;
                        next_s.bit_idx = 4'h0;
                    end
                end
                RX_RUN: begin
                    next_s.cnt = s.cnt + 4'h1;
                    if (s.cnt == SBR_SAMPLE_POINT) begin
                        next_s.shift = bits;
                        next_s.bit_idx = s.bit_idx + 4'h1;
                        if (s.bit_idx == 4'h0 && rxd) begin
                            // high at mid start bit: a glitch, not a start
                            next_s.st = RX_IDLE;
                        end else if (s.bit_idx == len - 4'h1) begin
                            next_s.done = 1'b1;
                            next_s.bit_idx = 4'h0;
                            next_s.frame.data = cfg.data7 ? {1'b0, bits[7:1]} : bits[8:1];
                            next_s.frame.parity_ok =
                                ((^next_s.frame.data) ^ bits[pidx]) == cfg.parity_odd;
                            next_s.frame.stop_ok = bits[sidx];
                            // line still low: next frame follows at once, so a
                            // break keeps producing framing errors
                            if (rxd) begin
                                next_s.st = RX_IDLE;
                            end
                        end
                    end
                end
                default: next_s.st = RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.last_rx <= 1'b1;
        end else if (ce) begin
            s <= next_s;
        end
    end

endmodule

`default_nettype wire

//--- sbr_uart_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_uart_assertions
    import sbr_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    // pins and interrupts
    input wire logic txd_out,
    input wire logic txd_oe,
    input wire logic irq,
    input wire logic rx_error_irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_aw_block;
        awvalid && awready |=> !awready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write address not blocked");
    property p_ar_answer;
        arvalid && arready |=> rvalid && !arready;
    endproperty
    a_ar_answer: assert property (p_ar_answer) else $error("read answer late");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data not held");
    property p_b_release;
        bvalid && bready |=> !bvalid && awready && wready;
    endproperty
    a_b_release: assert property (p_b_release) else $error("write channel not freed");
    property p_out_of_reset;
        $rose(aresetn) |-> awready && arready && !bvalid && !rvalid && !txd_oe && !irq;
    endproperty
    a_out_of_reset: assert property (p_out_of_reset) else $error("bad reset outputs");
    property p_err_data;
        rvalid && rresp == SBR_SLVERR |-> rdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error read data not zero");
    // the pin changes hands only through a register write
    property p_oe_by_write;
        $changed(txd_oe) |-> bvalid || $past(bvalid);
    endproperty
    a_oe_by_write: assert property (p_oe_by_write) else $error("pin enable moved alone");
    property p_rxerr_fall;
        $fell(rx_error_irq) |-> bvalid || $past(bvalid);
    endproperty
    a_rxerr_fall: assert property (p_rxerr_fall) else $error("error flag lost alone");

    c_rx_error: cover property (rx_error_irq);
    c_break_out: cover property (txd_oe && !txd_out);
    c_slverr: cover property (rvalid && rresp == SBR_SLVERR);
endmodule

`default_nettype wire

//--- sbr_remote_station.sv
`timescale 1ns/1ps
`default_nettype none

module sbr_remote_station
    import sbr_pkg::*;
#(
    parameter int BIT_CLKS = 16
) (
    // clock
    input wire logic aclk,
    // frame request
    input wire logic go,
    input wire logic [7:0] data,
    input wire sbr_frame_cfg_t cfg,
    input wire logic brk,
    // line and status
    output logic line,
    output logic busy
);
    logic level = 1'b1;
    logic [7:0] v;
    int i;

    // a held break wins over any frame in flight
    assign line = brk ? 1'b0 : level;

    task automatic bit_out(input logic b);
        level <= b;
        repeat (BIT_CLKS) @(posedge aclk);
    endtask

    initial begin
        busy = 1'b0;
        forever begin
            @(posedge aclk);
            if (go) begin
                busy <= 1'b1;
                v = cfg.data7 ? data & 8'h7f : data;
                bit_out(1'b0);
                for (i = 0; i < (cfg.data7 ? 7 : 8); i++) begin
                    bit_out(v[i]);
                end
                if (cfg.parity_en) bit_out(^v ^ cfg.parity_odd);
                bit_out(1'b1);
                if (cfg.stop2) bit_out(1'b1);
                busy <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
    import sbr_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hf;
    logic go = 1'b0, brk = 1'b0;
    logic [7:0] sdata = 8'h00, d;
    logic [9:0] f;
    sbr_frame_cfg_t scfg = 4'h0;
    sbr_frame_cfg_t cfgs [4] = '{4'h8, 4'h0, 4'h6, 4'h5};
    logic awready, wready, bvalid, arready, rvalid, rxd, txd_out, txd_oe;
    logic irq, rx_error_irq, st_busy;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int fails = 0, checks_done = 0, cyc = 0, seed = 76581, i, k;

    sbr_uart #(.DIV_W(16)) sbr_uart_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .rxd_pin(rxd),
        .txd_out(txd_out), .txd_oe(txd_oe), .sck_out(), .irq(irq),
        .rx_error_irq(rx_error_irq));
    sbr_remote_station sbr_remote_station_inst (.aclk(aclk), .go(go), .data(sdata),
        .cfg(scfg), .brk(brk), .line(rxd), .busy(st_busy));

    initial forever #12.5 aclk = ~aclk;

    task automatic final_report();
        $display("counts: checks=%0d mismatches=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [33:0] g, input logic [33:0] e);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
            fails++;
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] r = SBR_OKAY);
        bq.push_back(r);
        awaddr <= a;
        wdata <= 32'(v);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [4:0] a, input logic [33:0] e);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic send(input logic [7:0] v);
        sdata <= v;
        go <= 1'b1;
        @(posedge aclk);
        go <= 1'b0;
        repeat (2) @(posedge aclk);
        while (st_busy) @(posedge aclk);
        repeat (4) @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(SBR_STAT_OFS, 34'h21);
        rd(5'h02, {SBR_SLVERR, 32'h0000_0000});
        wr(5'h1e, 8'hff, SBR_SLVERR);
        rd(SBR_CLR_OFS, 34'h0);
        wr(SBR_PORT_OFS, 8'h03);
        chk(34'({txd_oe, txd_out}), 34'h3);
        wr(SBR_PORT_OFS, 8'h01);
        chk(34'({txd_oe, txd_out}), 34'h2);
        wr(SBR_PORT_OFS, 8'h03);
        wr(SBR_CTRL_OFS, 8'h01);
        d = 8'($random(seed));
        f = {1'b1, d, 1'b0};
        wr(SBR_TXD_OFS, d);
        repeat (8) @(posedge aclk);
        for (i = 0; i < 10; i++) begin
            chk(34'(txd_out), 34'(f[i]));
            repeat (16) @(posedge aclk);
        end
        // all-ones data so a low pin can only come from the port
        wr(SBR_TXD_OFS, 8'hff);
        repeat (40) @(posedge aclk);
        wr(SBR_PORT_OFS, 8'h01);
        chk(34'({txd_oe, txd_out}), 34'h3);
        wr(SBR_CTRL_OFS, 8'h00);
        chk(34'({txd_oe, txd_out}), 34'h2);
        rd(SBR_STAT_OFS, 34'h21);
        for (k = 0; k < 4; k++) begin
            scfg <= cfgs[k];
            wr(SBR_CTRL_OFS, {1'b1, cfgs[k].data7, cfgs[k].stop2, cfgs[k].parity_odd,
                cfgs[k].parity_en, 3'h2});
            d = 8'($random(seed));
            send(d);
            rd(SBR_RXD_OFS, 34'(cfgs[k].data7 ? d & 8'h7f : d));
            rd(SBR_STAT_OFS, 34'h23);
            wr(SBR_CLR_OFS, 8'h1e);
        end
        wr(SBR_CTRL_OFS, 8'h82);
        wr(SBR_IEN_OFS, 8'h08);
        brk <= 1'b1;
        repeat (400) @(posedge aclk);
        chk(34'({irq, rx_error_irq}), 34'h3);
        rd(SBR_STAT_OFS, 34'h0b);
        wr(SBR_CLR_OFS, 8'h1e);
        repeat (200) @(posedge aclk);
        rd(SBR_STAT_OFS, 34'h0b);
        wr(SBR_CLR_OFS, 8'h02);
        repeat (200) @(posedge aclk);
        rd(SBR_STAT_OFS, 34'h09);
        wr(SBR_CTRL_OFS, 8'h80);
        rd(SBR_STAT_OFS, 34'h09);
        chk(34'(rx_error_irq), 34'h1);
        wr(SBR_IEN_OFS, 8'h00);
        chk(34'(irq), 34'h0);
        brk <= 1'b0;
        repeat (50) @(posedge aclk);
        wr(SBR_CLR_OFS, 8'h1e);
        chk(34'(rx_error_irq), 34'h0);
        wr(SBR_CTRL_OFS, 8'h02);
        brk <= 1'b1;
        repeat (200) @(posedge aclk);
        brk <= 1'b0;
        repeat (200) @(posedge aclk);
        wr(SBR_CTRL_OFS, 8'h07);
        rd(SBR_CTRL_OFS, 34'h07);
        wr(SBR_TXD_OFS, 8'($random(seed)));
        repeat (20) @(posedge aclk);
        rd(SBR_STAT_OFS, 34'h2a);
        wr(SBR_CLR_OFS, 8'h1e);
        rd(SBR_STAT_OFS, 34'h61);
        final_report();
    end
endmodule

bind sbr_uart sbr_uart_assertions sbr_uart_assertions_inst (.aclk(aclk),
    .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .txd_out(txd_out), .txd_oe(txd_oe), .irq(irq), .rx_error_irq(rx_error_irq));

`default_nettype wire
